// >>> hw/cfe_pkg.sv
// Constants shared by the core fault detection logic
package cfe_pkg;
  // Op word field positions
  localparam int unsigned OP_LINE_MSB     = 15;
  localparam int unsigned OP_LINE_LSB     = 12;
  localparam int unsigned OP_MODE_MSB     = 11;
  localparam int unsigned OP_MODE_LSB     = 6;
  localparam int unsigned OP_EA_MSB       = 5;
  localparam int unsigned OP_EA_LSB       = 0;
  // Instruction lines with their own undefined-opcode vectors
  localparam logic [3:0]  LINE_A          = 4'ha;
  localparam logic [3:0]  LINE_F          = 4'hf;
  // Three-bit quick move: op mode bits 8..6 select it within line A
  localparam int unsigned QMOVE_SEL_MSB   = 8;
  localparam int unsigned QMOVE_SEL_LSB   = 6;
  localparam logic [2:0]  QMOVE_SEL_CODE  = 3'h5;
  // Debug data and debug register writes: bits 11..8 within line F
  localparam int unsigned DBGW_SEL_MSB    = 11;
  localparam int unsigned DBGW_SEL_LSB    = 8;
  localparam logic [3:0]  DBGW_SEL_CODE   = 4'hb;
  // Dedicated illegal op word, always an exception
  localparam logic [15:0] ILLEGAL_OPWORD  = 16'h4afc;
  // Indexed extension word 1 fields
  localparam int unsigned IDX_SIZE_BIT    = 11;
  localparam int unsigned IDX_SCALE_MSB   = 10;
  localparam int unsigned IDX_SCALE_LSB   = 9;
  localparam logic [1:0]  IDX_SCALE_EIGHT = 2'h3;
  localparam int unsigned IDX_FULL_BIT    = 8;
  // Branch target alignment bit
  localparam int unsigned TARGET_ODD_BIT  = 0;
  // Exception vector numbers
  localparam logic [7:0]  VEC_ACCESS      = 8'h02;
  localparam logic [7:0]  VEC_ADDRESS     = 8'h03;
  localparam logic [7:0]  VEC_ILLEGAL     = 8'h04;
  localparam logic [7:0]  VEC_LINE_A      = 8'h0a;
  localparam logic [7:0]  VEC_LINE_F      = 8'h0b;
  // Vector table entries are four bytes apart
  localparam int unsigned VEC_ENTRY_SHIFT = 2;
  // Fault status field encodings
  localparam logic [3:0]  FS_NONE         = 4'h0;
  localparam logic [3:0]  FS_FETCH        = 4'h4;
  localparam logic [3:0]  FS_OPR_WRITE    = 4'h8;
  localparam logic [3:0]  FS_OPR_READ     = 4'hc;
  // Reset values
  localparam logic [7:0]  VEC_RESET_VAL   = 8'h00;
  localparam logic [31:0] ADDR_RESET_VAL  = 32'h0000_0000;
endpackage : cfe_pkg

// >>> hw/cfe_fault_detect.sv
// Core fault detection and reset-or-exception response selection
`timescale 1ns/10ps
module cfe_fault_detect
  import cfe_pkg::*;
(
  input  wire logic        REF_CLK,                  // Core clock
  input  wire logic        RST,                      // Async reset
  input  wire logic        ADDR_FAULT_RESET_DISABLE, // Config bit
  input  wire logic        ILLEGAL_OP_RESET_DISABLE, // Config bit
  input  wire logic        BACKGROUND_DEBUG_ENABLE,  // Debug enable
  input  wire logic        STOP_MODE_EN,             // Low-power stop on
  input  wire logic        WAIT_MODE_EN,             // Wait mode on
  input  wire logic [31:0] VECTOR_BASE,              // Table base
  input  wire logic        FETCH_ERR,                // Prefetch error
  input  wire logic        FLOW_CHANGE,              // Prefetch flush
  input  wire logic        EXEC_VALID,               // Instr issues
  input  wire logic [15:0] EXEC_OPWORD,              // Op word
  input  wire logic [15:0] EXEC_EXT1,                // Extension word 1
  input  wire logic [31:0] EXEC_PC,                  // PC of instr
  input  wire logic        EXEC_OP_UNDEF,            // Main decode miss
  input  wire logic        EXEC_IS_STOP,             // Stop instruction
  input  wire logic        EXEC_IS_HALT,             // Halt instruction
  input  wire logic        EXEC_IS_NOP,              // No-op instruction
  input  wire logic        EXEC_IS_RETURN,           // Subroutine return
  input  wire logic        EXEC_INDEXED,             // Indexed EA used
  input  wire logic        EXEC_BRANCH,              // Control transfer
  input  wire logic [31:0] EXEC_TARGET,              // Transfer target
  input  wire logic        OPR_RD_ERR,               // Operand read error
  input  wire logic        WR_ERR,                   // Operand write error
  input  wire logic        WRITES_PENDING,           // Writes in flight
  output logic             EXC_TAKE,                 // Exception pulse
  output logic [7:0]       EXC_VECTOR,               // Vector number
  output logic [3:0]       EXC_FAULT_STATUS,         // Fault status
  output logic [31:0]      EXC_HANDLER_ADDR,         // Vector fetch addr
  output logic [31:0]      EXC_STACKED_PC,           // PC for frame
  output logic             EXC_OVER_RET,             // Frame over ret PC
  output logic             INSTR_ABORT,              // Abort pulse
  output logic             ARCH_KEEP,                // Keep part updates
  output logic             RESET_REQ,                // Reset request
  output logic             RESET_CAUSE_ADDR,         // Cause: address
  output logic             RESET_CAUSE_OP,           // Cause: opcode
  output logic             NOP_STALL                 // No-op held
);

  // Assertions below all run on the core clock and its reset
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  // Held fault state
  logic        fetch_pend_q;   // Fetch error waiting for use
  logic        fetch_pend_d;
  logic        wr_pend_q;      // Write error waiting for report
  logic        wr_pend_d;

  wire  [3:0]  op_line  = EXEC_OPWORD[OP_LINE_MSB:OP_LINE_LSB];
  wire  [2:0]  qmv_sel  = EXEC_OPWORD[QMOVE_SEL_MSB:QMOVE_SEL_LSB];
  wire  [3:0]  dbgw_sel = EXEC_OPWORD[DBGW_SEL_MSB:DBGW_SEL_LSB];

  wire         is_line_a = (op_line == LINE_A);
  wire         is_line_f = (op_line == LINE_F);

  // legal members of lines A and F
  wire         qmove_ok  = (qmv_sel == QMOVE_SEL_CODE);
  wire         dbgw_ok   = (dbgw_sel == DBGW_SEL_CODE);

  wire         a_undef   = is_line_a && !qmove_ok;
  wire         f_undef   = is_line_f && !dbgw_ok;
  wire         gen_undef = EXEC_OP_UNDEF && !is_line_a && !is_line_f;

  wire         illegal_op = (EXEC_OPWORD == ILLEGAL_OPWORD);

  // stop with no low-power mode enabled
  wire         stop_bad  = EXEC_IS_STOP && !STOP_MODE_EN && !WAIT_MODE_EN;

  wire         halt_bad  = EXEC_IS_HALT && !BACKGROUND_DEBUG_ENABLE;

  // illegality looks at the op word, the decode miss flag and the stop and halt enables
  wire         op_bad    = illegal_op || gen_undef || a_undef ||
                           f_undef || stop_bad || halt_bad;

  wire         odd_tgt   = EXEC_BRANCH && EXEC_TARGET[TARGET_ODD_BIT];

  // word index, scale of eight or full format
  wire         idx_word  = !EXEC_EXT1[IDX_SIZE_BIT];
  wire         idx_s8    =
    (EXEC_EXT1[IDX_SCALE_MSB:IDX_SCALE_LSB] == IDX_SCALE_EIGHT);
  wire         idx_full  = EXEC_EXT1[IDX_FULL_BIT];
  wire         idx_bad   = EXEC_INDEXED && (idx_word || idx_s8 || idx_full);
  wire         addr_bad  = odd_tgt || idx_bad;

  // no-op waits while writes remain in flight
  wire         nop_hold  = EXEC_VALID && EXEC_IS_NOP && WRITES_PENDING;
  wire         exec_go   = EXEC_VALID && !nop_hold;

  // Fault selection, highest priority first
  // read error aborts the running instruction at once
  wire         sel_rd = OPR_RD_ERR;
  // fetch error reported only when the word is executed
  wire         sel_if = !sel_rd && exec_go && fetch_pend_q;
  wire         sel_ad = !sel_rd && !sel_if && exec_go && addr_bad;
  wire         sel_il = !sel_rd && !sel_if && !sel_ad && exec_go && op_bad;
  // write error surfaces at an instruction boundary
  wire         sel_wr = !sel_rd && !sel_if && !sel_ad && !sel_il &&
                        exec_go && wr_pend_q;
  wire         sel_acc = sel_rd || sel_if || sel_wr;
  wire         any_flt = sel_acc || sel_ad || sel_il;

  wire  [7:0]  il_vec = (illegal_op || gen_undef || stop_bad || halt_bad) ?
                        VEC_ILLEGAL : (a_undef ? VEC_LINE_A : VEC_LINE_F);
  wire  [7:0]  vec_sel = sel_acc ? VEC_ACCESS :
                         (sel_ad ? VEC_ADDRESS : il_vec);

  wire  [3:0]  fs_sel = sel_rd ? FS_OPR_READ :
                        (sel_if ? FS_FETCH :
                        (sel_wr ? FS_OPR_WRITE : FS_NONE));

  // address-class response follows its disable bit
  wire         rst_addr = (sel_acc || sel_ad) && !ADDR_FAULT_RESET_DISABLE;
  // opcode-class response follows its disable bit
  // dedicated illegal op word never resets
  wire         rst_op   = sel_il && !illegal_op && !ILLEGAL_OP_RESET_DISABLE;
  wire         use_rst  = rst_addr || rst_op;

  // handler address is base plus vector times four
  wire  [31:0] vec_off  = 32'(vec_sel) << VEC_ENTRY_SHIFT;
  wire  [31:0] hnd_addr = VECTOR_BASE + vec_off;

  // abort: read, fetch, address and illegal faults; all but read leave state
  wire         abort_d  = sel_rd || sel_if || sel_ad || sel_il;

  // pending fetch error; a flush drops it, a new error wins
  assign fetch_pend_d = FETCH_ERR ||
                        (fetch_pend_q && !FLOW_CHANGE && !sel_if);
  // pending write error; a new error wins over the report
  assign wr_pend_d    = WR_ERR || (wr_pend_q && !sel_wr);

  // Pending fault flags
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      fetch_pend_q <= 1'b0;
      wr_pend_q    <= 1'b0;
    end else begin
      fetch_pend_q <= fetch_pend_d;
      wr_pend_q    <= wr_pend_d;
    end
  end

  // single-cycle reset request with cause flags
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      RESET_REQ        <= 1'b0;
      RESET_CAUSE_ADDR <= 1'b0;
      RESET_CAUSE_OP   <= 1'b0;
    end else begin
      RESET_REQ        <= any_flt && use_rst;
      RESET_CAUSE_ADDR <= any_flt && rst_addr;
      RESET_CAUSE_OP   <= any_flt && rst_op;
    end
  end

  // Exception pulse, abort marks and no-op stall
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      EXC_TAKE    <= 1'b0;
      INSTR_ABORT <= 1'b0;
      ARCH_KEEP   <= 1'b0;
      NOP_STALL   <= 1'b0;
    end else begin
      EXC_TAKE    <= any_flt && !use_rst;
      INSTR_ABORT <= abort_d;
      // read error keeps updates already made
      ARCH_KEEP   <= sel_rd;
      // stall while the no-op waits for writes
      NOP_STALL   <= nop_hold;
    end
  end

  // Frame contents, held until the next fault
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      EXC_VECTOR       <= VEC_RESET_VAL;
      EXC_FAULT_STATUS <= FS_NONE;
      EXC_HANDLER_ADDR <= ADDR_RESET_VAL;
      EXC_STACKED_PC   <= ADDR_RESET_VAL;
      EXC_OVER_RET     <= 1'b0;
    end else if (any_flt) begin
      EXC_VECTOR       <= vec_sel;
      EXC_FAULT_STATUS <= fs_sel;
      EXC_HANDLER_ADDR <= hnd_addr;
      // stacked PC is where the fault was signalled
      EXC_STACKED_PC   <= EXEC_PC;
      // return address error overwrites the return PC
      EXC_OVER_RET     <= sel_ad && EXEC_IS_RETURN;
    end
  end

  // Checks on the response logic

  acc_reset_sel_a: assert property (
    OPR_RD_ERR && !ADDR_FAULT_RESET_DISABLE |=> RESET_REQ && !EXC_TAKE)
    else $error("access error did not request reset");

  fetch_flush_a: assert property (
    FLOW_CHANGE && !FETCH_ERR |=> !fetch_pend_q)
    else $error("flushed fetch error still held");

  fetch_report_a: assert property (
    exec_go && fetch_pend_q && !OPR_RD_ERR
    |=> INSTR_ABORT && !ARCH_KEEP && EXC_FAULT_STATUS == FS_FETCH)
    else $error("fetch fault did not abort cleanly");

  read_abort_a: assert property (
    OPR_RD_ERR |=> INSTR_ABORT && ARCH_KEEP &&
    EXC_FAULT_STATUS == FS_OPR_READ)
    else $error("read fault handling wrong");

  wr_nop_report_a: assert property (
    WR_ERR ##1 (EXEC_VALID && EXEC_IS_NOP && !WRITES_PENDING &&
    !OPR_RD_ERR && !fetch_pend_q && !addr_bad && !op_bad)
    |=> (EXC_TAKE || RESET_REQ) && EXC_FAULT_STATUS == FS_OPR_WRITE)
    else $error("pending write error not reported on no-op");

  nop_stall_a: assert property (
    EXEC_VALID && EXEC_IS_NOP && WRITES_PENDING |=> NOP_STALL)
    else $error("no-op did not stall");

  wr_report_a: assert property (
    exec_go && wr_pend_q && !OPR_RD_ERR && !fetch_pend_q && !addr_bad &&
    !op_bad |=> EXC_FAULT_STATUS == FS_OPR_WRITE && !INSTR_ABORT &&
    EXC_STACKED_PC == $past(EXEC_PC))
    else $error("write error frame wrong");

  nop_refused_a: assert property (
    nop_hold && !OPR_RD_ERR |=> !EXC_TAKE && !RESET_REQ && !INSTR_ABORT)
    else $error("stalled no-op was checked");

  odd_target_a: assert property (
    exec_go && !OPR_RD_ERR && !fetch_pend_q && odd_tgt
    |=> EXC_VECTOR == VEC_ADDRESS && INSTR_ABORT)
    else $error("odd target missed");

  index_form_a: assert property (
    exec_go && idx_bad && !OPR_RD_ERR && !fetch_pend_q
    |=> EXC_VECTOR == VEC_ADDRESS && EXC_FAULT_STATUS == FS_NONE)
    else $error("bad index form missed");

  addr_reset_a: assert property (
    exec_go && addr_bad && !ADDR_FAULT_RESET_DISABLE && !OPR_RD_ERR &&
    !fetch_pend_q |=> RESET_REQ && RESET_CAUSE_ADDR && !EXC_TAKE)
    else $error("address error did not request reset");

  ret_frame_a: assert property (
    exec_go && addr_bad && EXEC_IS_RETURN && !OPR_RD_ERR && !fetch_pend_q
    |=> EXC_OVER_RET)
    else $error("return frame flag missing");

  illegal_word_a: assert property (
    exec_go && illegal_op && !OPR_RD_ERR && !fetch_pend_q && !addr_bad
    |=> EXC_TAKE && !RESET_REQ && EXC_VECTOR == VEC_ILLEGAL)
    else $error("dedicated illegal word misrouted");

  line_a_vec_a: assert property (
    exec_go && a_undef && !OPR_RD_ERR && !fetch_pend_q && !addr_bad
    |=> EXC_VECTOR == VEC_LINE_A)
    else $error("line A vector wrong");

  line_f_vec_a: assert property (
    exec_go && f_undef && !stop_bad && !halt_bad && !OPR_RD_ERR &&
    !fetch_pend_q && !addr_bad |=> EXC_VECTOR == VEC_LINE_F)
    else $error("line F vector wrong");

  legal_lines_a: assert property (
    exec_go && ((is_line_a && qmove_ok) || (is_line_f && dbgw_ok)) &&
    !stop_bad && !halt_bad && !OPR_RD_ERR && !fetch_pend_q &&
    !addr_bad && !wr_pend_q |=> !EXC_TAKE && !RESET_REQ)
    else $error("legal line A or F instruction faulted");

  stop_halt_a: assert property (
    exec_go && (stop_bad || halt_bad) && !OPR_RD_ERR && !fetch_pend_q &&
    !addr_bad |=> (EXC_TAKE || RESET_REQ) && EXC_VECTOR == VEC_ILLEGAL)
    else $error("disabled stop or halt not illegal");

  op_reset_a: assert property (
    exec_go && op_bad && !illegal_op && !ILLEGAL_OP_RESET_DISABLE &&
    !OPR_RD_ERR && !fetch_pend_q && !addr_bad
    |=> RESET_REQ && RESET_CAUSE_OP && !EXC_TAKE)
    else $error("illegal op did not request reset");

  handler_addr_a: assert property (
    EXC_TAKE |-> EXC_HANDLER_ADDR ==
    $past(VECTOR_BASE) + (32'(EXC_VECTOR) << VEC_ENTRY_SHIFT))
    else $error("handler address wrong");

  reset_pulse_a: assert property (
    RESET_REQ |-> (RESET_CAUSE_ADDR != RESET_CAUSE_OP) && !EXC_TAKE)
    else $error("reset request cause flags wrong");

  status_zero_a: assert property (
    (EXC_TAKE || RESET_REQ) && EXC_VECTOR != VEC_ACCESS
    |-> EXC_FAULT_STATUS == FS_NONE)
    else $error("fault status set on non-access fault");

  // Main scenarios
  cov_rd_err_c:  cover property (OPR_RD_ERR ##1 EXC_TAKE);
  cov_flush_c:   cover property (FETCH_ERR ##1 FLOW_CHANGE);
  cov_nop_wr_c:  cover property (NOP_STALL ##[1:20] EXC_TAKE);
  cov_op_rst_c:  cover property (RESET_REQ && RESET_CAUSE_OP);
  cov_ad_rst_c:  cover property (RESET_REQ && RESET_CAUSE_ADDR);

endmodule : cfe_fault_detect

// >>> tb/cfe_bus_model.sv
// Bus fabric and reset controller model facing the fault block
`timescale 1ns/10ps
module cfe_bus_model #(
  parameter int WR_LAT = 4      // Cycles a decoupled write stays in flight
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       inj_fetch,      // Fail the next fetch
  input  wire logic       inj_read,       // Fail the next operand read
  input  wire logic       wr_start,       // Launch a decoupled write
  input  wire logic       wr_bad,         // That write ends in error
  input  wire logic       reset_req,      // Request from the core
  output logic            fetch_err,
  output logic            rd_err,
  output logic            wr_err,
  output logic            writes_pending,
  output logic [7:0]      reset_seen      // Reset requests taken
);
  logic [3:0] wr_cnt_q;                    // Write cycles still to run
  logic       wr_bad_q;                    // Write will end in error
  // Read and fetch errors come back in the cycle they are asked for
  assign fetch_err      = inj_fetch;
  assign rd_err         = inj_read;
  assign writes_pending = (wr_cnt_q != 4'h0);
  // Error pulse on the last cycle of a failing write
  assign wr_err         = (wr_cnt_q == 4'h1) & wr_bad_q;
  // Write timer and reset request counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_cnt_q   <= 4'h0;
      wr_bad_q   <= 1'b0;
      reset_seen <= 8'h00;
    end else begin
      if (wr_start) begin
        wr_cnt_q <= WR_LAT[3:0];
        wr_bad_q <= wr_bad;
      end else if (writes_pending) begin
        wr_cnt_q <= wr_cnt_q - 4'h1;
      end
      if (reset_req) begin
        reset_seen <= reset_seen + 8'h01;
      end
    end
  end
endmodule // cfe_bus_model

// >>> tb/testbench.sv
// Self-checking bench for the core fault detection block
`timescale 1ns/10ps
module testbench;
  import cfe_pkg::*;
  logic REF_CLK, RST, ADDR_FAULT_RESET_DISABLE, ILLEGAL_OP_RESET_DISABLE;
  logic BACKGROUND_DEBUG_ENABLE, STOP_MODE_EN, WAIT_MODE_EN, FLOW_CHANGE;
  logic EXEC_VALID, EXEC_OP_UNDEF, EXEC_IS_STOP, EXEC_IS_HALT, EXEC_IS_NOP;
  logic EXEC_IS_RETURN, EXEC_INDEXED, EXEC_BRANCH;
  logic FETCH_ERR, OPR_RD_ERR, WR_ERR, WRITES_PENDING;
  logic EXC_TAKE, EXC_OVER_RET, INSTR_ABORT, ARCH_KEEP, RESET_REQ;
  logic RESET_CAUSE_ADDR, RESET_CAUSE_OP, NOP_STALL;
  logic [31:0] VECTOR_BASE, EXEC_PC, EXEC_TARGET;
  logic [31:0] EXC_HANDLER_ADDR, EXC_STACKED_PC;
  logic [15:0] EXEC_OPWORD, EXEC_EXT1;
  logic [7:0]  EXC_VECTOR, reset_seen;
  logic [3:0]  EXC_FAULT_STATUS;
  logic        inj_fetch, inj_read, wr_start, wr_bad, stall_seen;
  int          num_errors, checked, i, m, k;
  // Op word table: kind 0 legal, 1 follows disable bit, 2 always exception
  logic [15:0] t_op [0:8] = '{16'h4afc, 16'h4e7f, 16'ha000, 16'ha140,
    16'hf000, 16'hfb00, 16'h2030, 16'h4e72, 16'h4ac8};
  logic [7:0]  t_f  [0:8] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h20, 8'h10};
  logic [7:0]  t_v  [0:8] = '{8'h04, 8'h04, 8'h0a, 8'h00, 8'h0b, 8'h00,
    8'h00, 8'h04, 8'h04};
  int          t_k  [0:8] = '{2, 1, 1, 0, 1, 0, 0, 1, 1};
  // Index extension words: word index, scale eight, full format, valid
  logic [15:0] t_ext [0:3] = '{16'h0000, 16'h0e00, 16'h0900, 16'h0800};

  cfe_fault_detect cfe_fault_detect_i (.*);
  cfe_bus_model cfe_bus_model_i (
    .clk(REF_CLK), .rst(RST), .inj_fetch(inj_fetch), .inj_read(inj_read),
    .wr_start(wr_start), .wr_bad(wr_bad), .reset_req(RESET_REQ),
    .fetch_err(FETCH_ERR), .rd_err(OPR_RD_ERR), .wr_err(WR_ERR),
    .writes_pending(WRITES_PENDING), .reset_seen(reset_seen));

  // Core clock, 10 ns period
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // Compare one value and count it
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Print the verdict and stop
  task complete_run;
    $display("Checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Present one instruction for a cycle, then look at the answer
  task run(input logic [15:0] op, ext, input logic [7:0] f,
           input logic [31:0] tgt);
    @(posedge REF_CLK);
    EXEC_VALID  <= 1'b1;
    EXEC_OPWORD <= op;
    EXEC_EXT1   <= ext;
    EXEC_TARGET <= tgt;
    EXEC_PC     <= {16'h1000, op};
    {EXEC_OP_UNDEF, EXEC_IS_STOP, EXEC_IS_HALT, EXEC_IS_NOP,
     EXEC_IS_RETURN, EXEC_INDEXED, EXEC_BRANCH} <= f[6:0];
    @(posedge REF_CLK);
    EXEC_VALID  <= 1'b0;
    #1;
  endtask
  // Exception and reset pulses with the vector that goes with them
  task expect_fault(input logic take, rst, input logic [7:0] vec);
    chk(EXC_TAKE, take);
    chk(RESET_REQ, rst);
    if (take | rst) chk(EXC_VECTOR, vec);
  endtask
  // Bus error injection through the fabric model
  task inject(input logic f, r);
    @(posedge REF_CLK);
    inj_fetch <= f;
    inj_read  <= r;
    @(posedge REF_CLK);
    inj_fetch <= 1'b0;
    inj_read  <= 1'b0;
    #1;
  endtask
  // Change the two reset-disable bits
  task cfg(input logic a, il);
    @(posedge REF_CLK);
    ADDR_FAULT_RESET_DISABLE <= a;
    ILLEGAL_OP_RESET_DISABLE <= il;
  endtask

  // Watchdog far beyond the hundred or so cycles the tests need
  initial begin
    #20000;
    num_errors++;
    complete_run;
  end
  // Main sequence
  initial begin
    {RST, ADDR_FAULT_RESET_DISABLE, ILLEGAL_OP_RESET_DISABLE} = 3'b111;
    {BACKGROUND_DEBUG_ENABLE, STOP_MODE_EN, WAIT_MODE_EN} = 3'b110;
    {FLOW_CHANGE, EXEC_VALID, EXEC_OP_UNDEF, EXEC_IS_STOP} = 4'h0;
    {EXEC_IS_HALT, EXEC_IS_NOP, EXEC_IS_RETURN, EXEC_INDEXED} = 4'h0;
    {EXEC_BRANCH, inj_fetch, inj_read, wr_start, wr_bad} = 5'h00;
    {EXEC_OPWORD, EXEC_EXT1} = 32'h0;
    {VECTOR_BASE, EXEC_PC, EXEC_TARGET} = {32'h0080_0000, 64'h0};
    num_errors = 0;
    checked = 0;
    repeat (6) @(posedge REF_CLK);
    RST <= 1'b0;
    // Odd branch target with exceptions enabled
    run(16'h4ef9, 16'h0000, 8'h01, 32'h0000_1001);
    expect_fault(1'b1, 1'b0, VEC_ADDRESS);
    chk(EXC_HANDLER_ADDR, VECTOR_BASE + 32'h0000_000c);
    chk(EXC_STACKED_PC, 32'h1000_4ef9);
    chk(INSTR_ABORT, 1'b1);
    chk(EXC_FAULT_STATUS, FS_NONE);
    run(16'h4ef9, 16'h0000, 8'h01, 32'h0000_1002);
    expect_fault(1'b0, 1'b0, 8'h00);
    run(16'h4e75, 16'h0000, 8'h05, 32'h0000_1003);
    chk(EXC_OVER_RET, 1'b1);
    // Index extension word forms
    for (i = 0; i < 4; i++) begin
      run(16'h2030, t_ext[i], 8'h02, 32'h0);
      expect_fault(i < 3, 1'b0, VEC_ADDRESS);
      chk(EXC_OVER_RET, 1'b0);
    end
    // Address error with the reset response
    cfg(1'b0, 1'b1);
    run(16'h4ef9, 16'h0000, 8'h01, 32'h0000_2001);
    expect_fault(1'b0, 1'b1, VEC_ADDRESS);
    chk({RESET_CAUSE_ADDR, RESET_CAUSE_OP}, 2'b10);
    // Illegal op words, stop and halt, both disable settings
    @(posedge REF_CLK);
    {BACKGROUND_DEBUG_ENABLE, STOP_MODE_EN} <= 2'b00;
    for (m = 0; m < 2; m++) begin
      cfg(1'b1, m[0]);
      for (i = 0; i < 9; i++) begin
        k = t_k[i];
        run(t_op[i], ILLEGAL_OPWORD, t_f[i], 32'h0);
        expect_fault(k == 2 || (k == 1 && m == 1), k == 1 && m == 0,
                     t_v[i]);
        chk(RESET_CAUSE_OP, k == 1 && m == 0);
      end
    end
    @(posedge REF_CLK);
    {BACKGROUND_DEBUG_ENABLE, WAIT_MODE_EN} <= 2'b11;
    run(16'h4e72, 16'h0000, 8'h20, 32'h0);
    expect_fault(1'b0, 1'b0, 8'h00);
    run(16'h4ac8, 16'h0000, 8'h10, 32'h0);
    expect_fault(1'b0, 1'b0, 8'h00);
    // Operand read error, exception then reset response
    inject(1'b0, 1'b1);
    expect_fault(1'b1, 1'b0, VEC_ACCESS);
    chk({INSTR_ABORT, ARCH_KEEP, EXC_FAULT_STATUS}, {2'b11, FS_OPR_READ});
    cfg(1'b0, 1'b1);
    inject(1'b0, 1'b1);
    expect_fault(1'b0, 1'b1, VEC_ACCESS);
    // Fetch error held until the word is used
    cfg(1'b1, 1'b1);
    inject(1'b1, 1'b0);
    chk(EXC_TAKE, 1'b0);
    run(16'h2030, 16'h0000, 8'h00, 32'h0);
    expect_fault(1'b1, 1'b0, VEC_ACCESS);
    chk({INSTR_ABORT, ARCH_KEEP, EXC_FAULT_STATUS}, {2'b10, FS_FETCH});
    // Fetch error thrown away by a change of flow
    inject(1'b1, 1'b0);
    @(posedge REF_CLK);
    FLOW_CHANGE <= 1'b1;
    @(posedge REF_CLK);
    FLOW_CHANGE <= 1'b0;
    run(16'h2030, 16'h0000, 8'h00, 32'h0);
    expect_fault(1'b0, 1'b0, 8'h00);
    // Failing decoupled write collected by a stalled no-op
    @(posedge REF_CLK);
    {wr_start, wr_bad} <= 2'b11;
    @(posedge REF_CLK);
    wr_start <= 1'b0;
    EXEC_VALID <= 1'b1;
    {EXEC_OP_UNDEF, EXEC_IS_STOP, EXEC_IS_HALT, EXEC_IS_NOP,
     EXEC_IS_RETURN, EXEC_INDEXED, EXEC_BRANCH} <= 7'h08;
    stall_seen = 1'b0;
    for (i = 0; i < 20; i++) begin
      @(posedge REF_CLK);
      #1;
      stall_seen = stall_seen | (NOP_STALL === 1'b1);
      if (EXC_TAKE === 1'b1) break;
    end
    chk(stall_seen, 1'b1);
    expect_fault(1'b1, 1'b0, VEC_ACCESS);
    chk({INSTR_ABORT, EXC_FAULT_STATUS}, {1'b0, FS_OPR_WRITE});
    chk(EXC_STACKED_PC, 32'h1000_2030);
    @(posedge REF_CLK);
    EXEC_VALID <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    #1;
    chk(reset_seen, 8'd7);
    // Reset in mid-run clears the frame and drops a held fetch error
    inject(1'b1, 1'b0);
    @(posedge REF_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    #1;
    chk({EXC_TAKE, RESET_REQ, EXC_VECTOR}, 10'h000);
    run(16'h2030, 16'h0000, 8'h00, 32'h0);
    expect_fault(1'b0, 1'b0, 8'h00);
    complete_run;
  end
endmodule // testbench
